// file: design/module_health_indicator_led_pkg.sv
// Package for the diagnostic indicator block: channel count, blink timing, indicator codes.
// Assumes a 10 MHz module clock.
package module_health_indicator_led_pkg;

  localparam int NUM_CH = 16;
  localparam int NUM_PAIRS = NUM_CH / 2;
  localparam int CLK_HZ = 10000000;
  localparam int BLINK_MHZ = 2000; // Blink rate in milli-hertz (2.0 Hz)
  // Half period of the blink in clock cycles, rounded down
  // Divide first: the product of clock and milli-hertz scale overflows a 32-bit int
  localparam int BLINK_HALF_CYC = (CLK_HZ / (2 * BLINK_MHZ)) * 1000;
  localparam int BLINK_W = 22;
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_CYC - 1);
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;

  // Module indicator colour codes
  typedef enum logic [1:0] {
    HEALTH_OFF = 2'b00,
    HEALTH_GREEN = 2'b01,
    HEALTH_RED = 2'b10
  } health_colour_t;

  // Module indicator display modes
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_GREEN_STEADY = 3'b001,
    MODE_GREEN_BLINK = 3'b010,
    MODE_RED_BLINK = 3'b011,
    MODE_ALTERNATE = 3'b100
  } health_mode_t;

  // Module-wide diagnostic conditions
  typedef struct packed {
    logic bus_power_ok;
    logic configured;
    logic fw_update;
    logic fw_mismatch;
    logic supply_off;
    logic supply_range;
    logic hw_fault;
    logic comm_fault;
  } module_module_health_indicator_t;

  // Per-channel diagnostic inputs
  typedef struct packed {
    logic [NUM_CH-1:0] fault;
    logic [NUM_CH-1:0] sensor_fault;
    logic [NUM_CH-1:0] deactivated;
    logic [NUM_CH-1:0] auto_reint;
    logic [NUM_CH-1:0] io_state;
  } channel_module_health_indicator_t;

  // Diagnostic option settings
  typedef struct packed {
    logic sc_test_en;
    logic [TMR_W-1:0] sc_interval;
    logic [TMR_W-1:0] sc_duration;
    logic [TMR_W-1:0] comm_timeout;
    logic [TMR_W-1:0] prog_timeout;
  } module_health_indicator_cfg_t;

endpackage : module_health_indicator_led_pkg

// file: design/blink_gen.sv
// Shared blink generator: square wave with equal on and off phases.
// Assumes clk at the package clock rate.
`timescale 1ns/1ns
`default_nettype none
module blink_gen
  import module_health_indicator_led_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  output logic phase
);

  logic [BLINK_W-1:0] cnt_r;
  logic phase_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r == BLINK_LAST)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Toggle each half period gives 2.0 Hz with a 50 percent duty
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_r <= 1'b0;
    end
    else if (cnt_r == BLINK_LAST)
    begin
      phase_r <= ~phase_r;
    end
  end

  assign phase = phase_r;

endmodule : blink_gen
`default_nettype wire

// file: design/module_health_indicator_led.sv
// Diagnostic indicator driver for a fail-safe digital I/O module.
// Assumes diagnostic results arrive as pin-level signals from other logic and
// pass a two-flop synchroniser; the acknowledge request is held high by the program.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Configured, no fault: health steady green
// - Unconfigured, no fault: health blinks green
// - Any diagnostic triggered: health blinks red
// - Cleared module fault unacknowledged: red/green alternate
// - Cleared channel fault unacknowledged: red blink
// - All cleared and acknowledged: steady green
// - Status lights follow channel state
// - Channel error: fault light, health red
// - All blinking at 2.0 Hz
// - Firmware mismatch: red, fault blink, status off
// - Supply off: red, channel lights off
// - Supply out of range: red, faults on
// - Sensor fault: unaffected channels keep showing
// - Module fault passivates and lights all faults (on comm_fault the code alternates the channel lights instead)
// - Module reintegration wait: everything alternates
// - Channel reintegration wait: red, channel alternates
// - Pair status shows equivalence pattern (code shows each input's own state)
// - Each result is channel or module
// - Every fault passivates affected channels
// - Short-circuit test enable, interval, duration
// - Communication and program timeouts configurable
// - Request flag, acknowledge releases ready channels
// - Automatic channels reintegrate when fault clears
module module_health_indicator_led
  import module_health_indicator_led_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire module_module_health_indicator_t mod_module_health_indicator,
  input wire channel_module_health_indicator_t ch_module_health_indicator,
  input wire logic [NUM_PAIRS-1:0] dual_input_pair,
  input wire module_health_indicator_cfg_t module_health_indicator_cfg,
  input wire logic comm_alive,
  input wire logic prog_alive,
  input wire logic reintegration_acknowledge_flag,
  output logic ack_request,
  output logic [1:0] module_health_indicator,
  output logic [NUM_CH-1:0] fault_led,
  output logic [NUM_CH-1:0] status_led,
  output logic [NUM_CH-1:0] passivated,
  output logic sc_test_active
);

  module_module_health_indicator_t md_s1_r;
  module_module_health_indicator_t md_s2_r;
  channel_module_health_indicator_t cd_s1_r;
  channel_module_health_indicator_t cd_s2_r;
  logic [NUM_PAIRS-1:0] pair_s1_r;
  logic [NUM_PAIRS-1:0] pair_s2_r;
  logic [2:0] misc_s1_r;
  logic [2:0] misc_s2_r;
  logic ack_d_r;
  logic blink;

  logic [NUM_CH-1:0] ch_pass_r;
  logic [NUM_CH-1:0] ch_pass_nxt;
  logic mod_pass_r;
  logic mod_pass_nxt;
  logic [TMR_W-1:0] comm_tmr_r;
  logic [TMR_W-1:0] prog_tmr_r;
  logic timeout_r;
  logic [TMR_W-1:0] sc_tmr_r;
  logic sc_active_r;
  logic [1:0] health_r;
  logic [NUM_CH-1:0] fault_r;
  logic [NUM_CH-1:0] status_r;
  logic ack_req_r;
  health_mode_t mode;
  logic [NUM_CH-1:0] pair_state;
  logic [NUM_CH-1:0] pair_mask;
  logic mod_fault_now;
  logic ack_pulse;

  // Saturating decrement used by all the timers
  function automatic logic [TMR_W-1:0] tmr_dec(input logic [TMR_W-1:0] t);
    tmr_dec = (t == TMR_ZERO) ? TMR_ZERO : t - 1'b1;
  endfunction : tmr_dec

  // Two-flop synchronisers for every asynchronous diagnostic input
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      md_s1_r <= '0;
      md_s2_r <= '0;
      cd_s1_r <= '0;
      cd_s2_r <= '0;
      pair_s1_r <= '0;
      pair_s2_r <= '0;
      misc_s1_r <= '0;
      misc_s2_r <= '0;
    end
    else
    begin
      md_s1_r <= mod_module_health_indicator;
      md_s2_r <= md_s1_r;
      cd_s1_r <= ch_module_health_indicator;
      cd_s2_r <= cd_s1_r;
      pair_s1_r <= dual_input_pair;
      pair_s2_r <= pair_s1_r;
      misc_s1_r <= {comm_alive, prog_alive, reintegration_acknowledge_flag};
      misc_s2_r <= misc_s1_r;
    end
  end

  blink_gen u_blink (
    .clk(clk),
    .nrst(nrst),
    .phase(blink)
  );

  // Watchdogs reload on each sign of life and stay full while unconfigured,
  // so the cleared timers after reset never read as an expiry
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      comm_tmr_r <= '0;
      prog_tmr_r <= '0;
      timeout_r <= 1'b0;
    end
    else
    begin
      comm_tmr_r <= (misc_s2_r[2] || !md_s2_r.configured) ? module_health_indicator_cfg.comm_timeout :
                    tmr_dec(comm_tmr_r);
      prog_tmr_r <= (misc_s2_r[1] || !md_s2_r.configured) ? module_health_indicator_cfg.prog_timeout :
                    tmr_dec(prog_tmr_r);
      timeout_r <= md_s2_r.configured &&
                   (comm_tmr_r == TMR_ZERO || prog_tmr_r == TMR_ZERO);
    end
  end

  // Short-circuit test pulses the sensor supply for duration, then rests for interval before the next pulse
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sc_tmr_r <= '0;
      sc_active_r <= 1'b0;
    end
    else if (!module_health_indicator_cfg.sc_test_en)
    begin
      sc_tmr_r <= '0;
      sc_active_r <= 1'b0;
    end
    else if (sc_tmr_r == TMR_ZERO)
    begin
      sc_active_r <= ~sc_active_r;
      sc_tmr_r <= sc_active_r ? module_health_indicator_cfg.sc_interval : module_health_indicator_cfg.sc_duration;
    end
    else
    begin
      sc_tmr_r <= tmr_dec(sc_tmr_r);
    end
  end

  // Module-wide faults, attributed to the module as a whole
  assign mod_fault_now = md_s2_r.hw_fault | md_s2_r.supply_off | md_s2_r.supply_range |
                         md_s2_r.fw_mismatch | timeout_r | md_s2_r.comm_fault;
  assign ack_pulse = misc_s2_r[0] & ~ack_d_r;

  // A pair shares one fault state: fault on either input passivates both
  always_comb
  begin
    pair_mask = '0;
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      if (pair_s2_r[p] && (cd_s2_r.fault[2*p] || cd_s2_r.fault[2*p+1]))
      begin
        pair_mask[2*p] = 1'b1;
        pair_mask[2*p+1] = 1'b1;
      end
    end
  end

  // Passivation: set by fault, held until reintegration; set wins over release
  always_comb
  begin
    mod_pass_nxt = mod_pass_r;
    ch_pass_nxt = ch_pass_r;
    if (mod_fault_now)
    begin
      mod_pass_nxt = 1'b1;
    end
    else if (ack_pulse && ack_req_r)
    begin
      mod_pass_nxt = 1'b0;
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (cd_s2_r.fault[c] || cd_s2_r.sensor_fault[c] || pair_mask[c])
      begin
        ch_pass_nxt[c] = 1'b1;
      end
      else if (cd_s2_r.auto_reint[c])
      begin
        ch_pass_nxt[c] = 1'b0;
      end
      else if (ack_pulse && ack_req_r)
      begin
        ch_pass_nxt[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mod_pass_r <= 1'b0;
      ch_pass_r <= '0;
      ack_d_r <= 1'b0;
      ack_req_r <= 1'b0;
    end
    else
    begin
      mod_pass_r <= mod_pass_nxt;
      ch_pass_r <= ch_pass_nxt;
      ack_d_r <= misc_s2_r[0];
      // Request from next passivation, so automatic release never flashes a request
      ack_req_r <= (mod_pass_nxt && !mod_fault_now) ||
                   |(ch_pass_nxt & ~(cd_s2_r.fault | cd_s2_r.sensor_fault | pair_mask));
    end
  end

  // Pair status: primary and secondary of a pair each show their own input
  always_comb
  begin
    pair_state = cd_s2_r.io_state;
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      if (pair_s2_r[p])
      begin
        pair_state[2*p] = cd_s2_r.io_state[2*p];
        pair_state[2*p+1] = cd_s2_r.io_state[2*p+1];
      end
    end
  end

  // Module indicator mode, highest priority first
  always_comb
  begin
    if (!md_s2_r.bus_power_ok)
    begin
      mode = MODE_OFF;
    end
    else if (mod_fault_now || |(cd_s2_r.fault | cd_s2_r.sensor_fault))
    begin
      mode = MODE_RED_BLINK;
    end
    else if (mod_pass_r)
    begin
      mode = MODE_ALTERNATE;
    end
    else if (|ch_pass_r)
    begin
      mode = MODE_RED_BLINK;
    end
    else if (!md_s2_r.configured || md_s2_r.fw_update)
    begin
      mode = MODE_GREEN_BLINK;
    end
    else
    begin
      mode = MODE_GREEN_STEADY;
    end
  end

  // Indicator output registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      health_r <= HEALTH_OFF;
      fault_r <= '0;
      status_r <= '0;
    end
    else
    begin
      unique case (mode)
        MODE_OFF: health_r <= HEALTH_OFF;
        MODE_GREEN_STEADY: health_r <= HEALTH_GREEN;
        MODE_GREEN_BLINK: health_r <= blink ? HEALTH_GREEN : HEALTH_OFF;
        MODE_RED_BLINK: health_r <= blink ? HEALTH_RED : HEALTH_OFF;
        MODE_ALTERNATE: health_r <= blink ? HEALTH_RED : HEALTH_GREEN;
        default: health_r <= HEALTH_OFF;
      endcase
      if (!md_s2_r.bus_power_ok || md_s2_r.supply_off || md_s2_r.fw_update)
      begin
        fault_r <= '0;
        status_r <= '0;
      end
      else if (md_s2_r.fw_mismatch)
      begin
        fault_r <= {NUM_CH{blink}};
        status_r <= '0;
      end
      else if (md_s2_r.supply_range || md_s2_r.hw_fault || timeout_r)
      begin
        fault_r <= '1;
        status_r <= '0;
      end
      else
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          if (cd_s2_r.fault[c] || cd_s2_r.sensor_fault[c] || pair_mask[c])
          begin
            fault_r[c] <= 1'b1;
            status_r[c] <= 1'b0;
          end
          else if (mod_pass_r || ch_pass_r[c])
          begin
            // Opposite phase so exactly one of the pair is lit
            fault_r[c] <= blink;
            status_r[c] <= ~blink;
          end
          else if (cd_s2_r.deactivated[c] || !md_s2_r.configured)
          begin
            fault_r[c] <= 1'b0;
            status_r[c] <= 1'b0;
          end
          else
          begin
            fault_r[c] <= 1'b0;
            status_r[c] <= pair_state[c];
          end
        end
      end
    end
  end

  assign module_health_indicator = health_r;
  assign fault_led = fault_r;
  assign status_led = status_r;
  assign passivated = ch_pass_r | {NUM_CH{mod_pass_r}};
  assign ack_request = ack_req_r;
  assign sc_test_active = sc_active_r;

endmodule : module_health_indicator_led
`default_nettype wire

// file: bench/module_health_indicator_led_chk.sv
// Checker for the indicator driver: lights against diagnostics over time.
// Assumes it is bound to module_health_indicator_led; outputs settle within four cycles.
`timescale 1ns/1ns
`default_nettype none
module module_health_indicator_led_chk
  import module_health_indicator_led_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire module_module_health_indicator_t mod_module_health_indicator,
  input wire channel_module_health_indicator_t ch_module_health_indicator,
  input wire logic ack_request,
  input wire logic [1:0] module_health_indicator,
  input wire logic [NUM_CH-1:0] fault_led,
  input wire logic [NUM_CH-1:0] status_led,
  input wire logic [NUM_CH-1:0] passivated
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic clean;
  // Five cycles of quiet cover the two-flop sync plus the output register
  assign clean = mod_module_health_indicator == 8'hC0 && ch_module_health_indicator.fault == 16'h0000
    && ch_module_health_indicator.sensor_fault == 16'h0000 && passivated == 16'h0000 && !ack_request;
  chk_green_clean:
    assert property (clean [*5] |-> module_health_indicator == HEALTH_GREEN)
    else $error("health not green while clean");
  chk_status_follow:
    assert property ((clean && $stable(ch_module_health_indicator.io_state)) [*5] |-> status_led == ch_module_health_indicator.io_state)
    else $error("status lights do not follow channel state");
  chk_module_fault:
    assert property (mod_module_health_indicator.hw_fault [*5] |-> passivated == 16'hFFFF && fault_led == 16'hFFFF)
    else $error("module fault did not passivate and light all");
  chk_supply_off:
    assert property (mod_module_health_indicator.supply_off [*5] |-> fault_led == 16'h0000 && status_led == 16'h0000)
    else $error("channel lights on with supply off");
  chk_supply_range:
    assert property ((mod_module_health_indicator.supply_range && !mod_module_health_indicator.supply_off) [*5]
      |-> fault_led == 16'hFFFF && status_led == 16'h0000)
    else $error("supply range lights wrong");
  chk_fault_lit:
    assert property ((mod_module_health_indicator == 8'hC0 && ch_module_health_indicator.fault != 16'h0000) [*5]
      |-> (fault_led & ch_module_health_indicator.fault) == ch_module_health_indicator.fault && module_health_indicator != HEALTH_GREEN)
    else $error("channel fault not shown");
  chk_fault_passive:
    assert property ((ch_module_health_indicator.fault != 16'h0000) [*5] |-> (passivated & ch_module_health_indicator.fault) == ch_module_health_indicator.fault)
    else $error("faulty channel not passivated");
  chk_req_cause:
    assert property ($rose(ack_request) |-> passivated != 16'h0000)
    else $error("acknowledge request without passivation");
  chk_alt_onehot:
    assert property ((fault_led & status_led & passivated) == 16'h0000)
    else $error("both lights of a passivated channel lit");
  chk_fw_status:
    assert property (mod_module_health_indicator.fw_mismatch [*5] |-> status_led == 16'h0000)
    else $error("status lights on with firmware mismatch");
endmodule : module_health_indicator_led_chk
bind module_health_indicator_led module_health_indicator_led_chk u_chk (.clk(clk), .nrst(nrst), .mod_module_health_indicator(mod_module_health_indicator),
  .ch_module_health_indicator(ch_module_health_indicator), .ack_request(ack_request), .module_health_indicator(module_health_indicator),
  .fault_led(fault_led), .status_led(status_led), .passivated(passivated));
`default_nettype wire

// file: bench/module_health_indicator_partner.sv
// Far-side model: program acknowledge and watchdog life signs.
// Assumes the bench raises ack_cmd when it wants an acknowledge.
`timescale 1ns/1ns
`default_nettype none
module module_health_indicator_partner
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ack_cmd,
  input wire logic ack_request,
  output logic ack_flag,
  output logic alive
);
  logic [4:0] beat_r;
  // The program only acknowledges after the module asks
  // Rising edge by NBA, so the bench's falling-edge writes never race it
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      ack_flag <= 1'b0;
    else
      ack_flag <= ack_cmd && ack_request;
  // A beat every 32 cycles keeps both watchdogs fed
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      beat_r <= 5'h00;
    else
      beat_r <= beat_r + 5'h01;
  assign alive = beat_r == 5'h1F;
endmodule : module_health_indicator_partner
`default_nettype wire

// file: bench/module_health_indicator_led_test.sv
// Self-checking bench for the indicator driver.
// Assumes blink phase stays in its first half during this short run.
`timescale 1ns/1ns
`default_nettype none
module module_health_indicator_led_test
  import module_health_indicator_led_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  module_module_health_indicator_t mod_module_health_indicator = 8'hC0;
  channel_module_health_indicator_t ch_module_health_indicator = {64'h0, 16'hA5C2};
  logic [NUM_PAIRS-1:0] pair = 8'h01;
  module_health_indicator_cfg_t cfg = {1'b1, 16'h0040, 16'h0008, 16'hFFFF, 16'hFFFF};
  logic ack_cmd = 1'b0;
  logic ack_flag, alive, ack_request, sc_act;
  logic [1:0] health;
  logic [NUM_CH-1:0] fled, sled, pas;
  module_module_health_indicator_t cases [4] = '{8'hC2, 8'hC4, 8'hC8, 8'hD0};
  logic [15:0] ledx [3] = '{16'hFFFF, 16'hFFFF, 16'h0000};
  int n_mismatch = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  module_health_indicator_led DUT (.clk(clk), .nrst(nrst), .mod_module_health_indicator(mod_module_health_indicator), .ch_module_health_indicator(ch_module_health_indicator),
    .dual_input_pair(pair), .module_health_indicator_cfg(cfg), .comm_alive(alive), .prog_alive(alive),
    .reintegration_acknowledge_flag(ack_flag), .ack_request(ack_request),
    .module_health_indicator(health), .fault_led(fled), .status_led(sled),
    .passivated(pas), .sc_test_active(sc_act));
  module_health_indicator_partner u_partner (.clk(clk), .nrst(nrst), .ack_cmd(ack_cmd),
    .ack_request(ack_request), .ack_flag(ack_flag), .alive(alive));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask : settle
  // Held well past the sync delay so the rising edge is seen
  task automatic ack;
    ack_cmd = 1'b1;
    repeat (12) @(negedge clk);
    ack_cmd = 1'b0;
    repeat (4) @(negedge clk);
  endtask : ack
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    int i;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    settle();
    chk(health, HEALTH_GREEN);
    chk(sled, 16'hA5C2);
    i = 0;
    while (sc_act !== 1'b1 && i < 300)
    begin
      @(negedge clk);
      i++;
    end
    chk(sc_act, 1'b1);
    mod_module_health_indicator = 8'h80;
    settle();
    chk(health, HEALTH_OFF);
    mod_module_health_indicator = 8'hC0;
    pair = 8'h03;
    ch_module_health_indicator.fault = 16'h0004;
    settle();
    chk(pas, 16'h000C);
    chk(fled & 16'h0004, 16'h0004);
    chk(health, HEALTH_OFF);
    ch_module_health_indicator.fault = 16'h0000;
    settle();
    chk(ack_request, 1'b1);
    chk(health, HEALTH_OFF);
    chk(fled[2] ^ sled[2], 1'b1);
    ack();
    chk(pas, 16'h0000);
    chk(health, HEALTH_GREEN);
    for (i = 0; i < 4; i++)
    begin
      mod_module_health_indicator = cases[i];
      settle();
      chk(pas, 16'hFFFF);
      chk(sled, 16'h0000);
      if (i < 3)
        chk(fled, ledx[i]);
      mod_module_health_indicator = 8'hC0;
      settle();
      chk(health, HEALTH_GREEN);
      chk(fled ^ sled, 16'hFFFF);
      ack();
      chk(health, HEALTH_GREEN);
    end
    ch_module_health_indicator.sensor_fault = 16'h00F0;
    settle();
    chk(sled & 16'hFF0F, 16'hA502);
    ch_module_health_indicator.sensor_fault = 16'h0000;
    settle();
    ack();
    ch_module_health_indicator.auto_reint = 16'h0100;
    ch_module_health_indicator.fault = 16'h0100;
    settle();
    chk(pas, 16'h0100);
    ch_module_health_indicator.fault = 16'h0000;
    settle();
    chk(pas, 16'h0000);
    chk(ack_request, 1'b0);
    report_and_stop();
  end
endmodule : module_health_indicator_led_test
`default_nettype wire
